// ### mcuie_pkg.sv
package mcuie_pkg;

   // Bus geometry.
   localparam int          AXI_ADDR_W        = 8;
   localparam int          AXI_DATA_W        = 32;
   localparam logic [1:0]  AXI_RESP_OKAY     = 2'h0;
   localparam logic [1:0]  AXI_RESP_SLVERR   = 2'h2;

   // Register byte addresses.
   localparam logic [7:0]  ADDR_IRQ_ENABLE   = 8'h00;
   localparam logic [7:0]  ADDR_MCU_CONFIG   = 8'h04;
   localparam logic [7:0]  ADDR_EVT_STATUS   = 8'h08;
   localparam logic [7:0]  ADDR_EVT_MASK     = 8'h0c;
   localparam logic [7:0]  ADDR_REQ_STATUS   = 8'h10;
   localparam logic [7:0]  ADDR_VECTOR       = 8'h14;

   // Bit positions in the enable register.
   localparam int          EN_INTERNAL_BIT   = 0;
   localparam int          EN_TIMER0_BIT     = 1;
   localparam int          EN_EXT1_BIT       = 2;
   localparam int          EN_TIMER1_BIT     = 3;
   localparam int          EN_SERIAL_BIT     = 4;
   localparam int          EN_TIMER2_BIT     = 5;
   localparam int          EN_RESERVED_BIT   = 6;
   localparam int          EN_GLOBAL_BIT     = 7;
   localparam logic [7:0]  EN_WRITE_MASK     = 8'hbf;
   localparam logic [7:0]  EN_RESET          = 8'h00;

   // Bit position in the configuration register.
   localparam int          CFG_IRQ1_SEL_BIT  = 0;
   localparam logic [7:0]  CFG_RESET         = 8'h00;

   // Number of classic sources; request, status and mask bits follow the enable layout.
   localparam int          NUM_SRC           = 6;
   localparam logic [5:0]  SRC_RESET         = 6'h00;

   // Width of the peripheral request bundle and of port 2.
   localparam int          NUM_PERIPH        = 16;
   localparam int          PORT2_W           = 8;

   // Service start locations.
   localparam logic [15:0] VEC_RESET         = 16'h0000;
   localparam logic [15:0] VEC_INTERNAL      = 16'h0003;
   localparam logic [15:0] VEC_TIMER0        = 16'h000b;
   localparam logic [15:0] VEC_EXT1          = 16'h0013;
   localparam logic [15:0] VEC_TIMER1        = 16'h001b;
   localparam logic [15:0] VEC_SERIAL        = 16'h0023;
   localparam logic [15:0] VEC_TIMER2        = 16'h002b;

endpackage : mcuie_pkg

// ### mcuie_sync.sv
`timescale 1ns/1ps
module mcuie_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // Clock and reset.
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // Asynchronous input and its synchronised copy.
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // Pins idle high, so the reset value keeps the active-low lines quiet.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : mcuie_sync

// ### mcuie_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Keep all six classic sources, each with own enable bit and fixed start location.
// - OR every on-chip peripheral request into one internal interrupt-0 line.
// - Internal interrupt-0 serves all peripherals, service starts at 0003H.
// - External interrupt-1 carries the port-2 interrupt, service starts at 0013H.
// - Timers start at 000BH, 001BH, 002BH; reset entry is 0000H.
// - Enable bit 4 gates serial interrupt at 0023H; resets to disabled.
// - Enable bit 0 gates internal interrupt-0; resets to zero.
// - Enable bit 2 gates external interrupt-1; resets to zero.
// - Enable bits 1, 3, 5 gate timers 0, 1, 2; reset to zero.
// - Enable bit 7 is global enable; zero blocks every core request but not the event irq; resets to zero.
// - Active-low port-2 inputs OR into level interrupt-1, also sent to wake-up logic.
// - Configuration bit selects interrupt-1 source: zero port-3 pin 3, one port 2.
module mcuie_ctrl
   import mcuie_pkg::*;
(
   // Clock and reset.
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   // AXI4-Lite write address channel.
   input  wire logic [AXI_ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   // AXI4-Lite write data channel.
   input  wire logic [AXI_DATA_W-1:0]   s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // AXI4-Lite read address channel.
   input  wire logic [AXI_ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [AXI_DATA_W-1:0]        s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // Request sources on the core clock, active high.
   input  wire logic [NUM_PERIPH-1:0]   periph_irq,
   input  wire logic                    timer0_irq,
   input  wire logic                    timer1_irq,
   input  wire logic                    timer2_irq,
   input  wire logic                    serial_irq,
   // Pins, active low.
   input  wire logic [PORT2_W-1:0]      port2_in_n,
   input  wire logic                    p3_3_in_n,
   // Toward the core.
   output logic                         internal_irq_line_n,
   output logic [NUM_SRC-1:0]           core_irq_req,
   output logic [15:0]                  core_irq_vector,
   output logic                         core_irq_valid,
   // Toward suspend and resume logic.
   output logic                         port2_irq_line_n,
   // Event interrupt.
   output logic                         irq
);

   logic [PORT2_W-1:0]  port2_s;
   logic                p3_3_s;
   logic [7:0]          irq_enable_reg_q;
   logic [7:0]          mcu_config_reg_q;
   logic [NUM_SRC-1:0]  evt_status_q;
   logic [NUM_SRC-1:0]  evt_mask_q;
   logic [NUM_SRC-1:0]  raw_req;
   logic [NUM_SRC-1:0]  raw_req_q;
   logic [NUM_SRC-1:0]  gated_req;
   logic                internal_req;
   logic                port2_req;
   logic                ext1_req;
   logic                irq1_source_select;
   logic                global_irq_enable;
   logic [15:0]         vector_d;

   // Write channel state.
   logic [AXI_ADDR_W-1:0] awaddr_q;
   logic                  aw_held_q;
   logic [AXI_DATA_W-1:0] wdata_q;
   logic [3:0]            wstrb_q;
   logic                  w_held_q;
   logic                  aw_hit;
   logic                  w_hit;
   logic                  do_write;
   logic [AXI_ADDR_W-1:0] wr_addr;
   logic [AXI_DATA_W-1:0] wr_data;
   logic [3:0]            wr_strb;
   logic                  wr_byte0;
   logic                  wr_mapped;
   logic                  wr_en_sel;
   logic                  wr_cfg_sel;
   logic                  wr_sts_sel;
   logic                  wr_msk_sel;

   // Read channel state.
   logic                  ar_hit;
   logic [AXI_DATA_W-1:0] rd_data;
   logic [1:0]            rd_resp;

   // Pins cross into the core clock before any logic looks at them.
   mcuie_sync #(
      .W       (PORT2_W),
      .RST_VAL ({PORT2_W{1'b1}})
   ) u_sync_port2 (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (port2_in_n),
      .sync_out (port2_s)
   );

   mcuie_sync #(
      .W       (1),
      .RST_VAL (1'b1)
   ) u_sync_p33 (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (p3_3_in_n),
      .sync_out (p3_3_s)
   );

   // Request combination and source selection.
   assign internal_req       = |periph_irq;
   assign internal_irq_line_n = ~internal_req;
   assign port2_req          = ~(&port2_s);
   assign port2_irq_line_n   = ~port2_req;
   assign irq1_source_select = mcu_config_reg_q[CFG_IRQ1_SEL_BIT];
   assign ext1_req           = irq1_source_select ? port2_req : ~p3_3_s;

   always_comb begin
      raw_req                  = SRC_RESET;
      raw_req[EN_INTERNAL_BIT] = internal_req;
      raw_req[EN_TIMER0_BIT]   = timer0_irq;
      raw_req[EN_EXT1_BIT]     = ext1_req;
      raw_req[EN_TIMER1_BIT]   = timer1_irq;
      raw_req[EN_SERIAL_BIT]   = serial_irq;
      raw_req[EN_TIMER2_BIT]   = timer2_irq;
   end

   // Gating toward the core; the global bit overrides every source.
   assign global_irq_enable = irq_enable_reg_q[EN_GLOBAL_BIT];

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_gate
         assign gated_req[g] = raw_req[g] & irq_enable_reg_q[g]
                               & global_irq_enable;
      end
   endgenerate

   assign core_irq_req = gated_req;

   // Fixed start location of the highest-priority pending source.
   always_comb begin
      vector_d = VEC_RESET;
      if (gated_req[EN_INTERNAL_BIT]) begin
         vector_d = VEC_INTERNAL;
      end else if (gated_req[EN_TIMER0_BIT]) begin
         vector_d = VEC_TIMER0;
      end else if (gated_req[EN_EXT1_BIT]) begin
         vector_d = VEC_EXT1;
      end else if (gated_req[EN_TIMER1_BIT]) begin
         vector_d = VEC_TIMER1;
      end else if (gated_req[EN_SERIAL_BIT]) begin
         vector_d = VEC_SERIAL;
      end else if (gated_req[EN_TIMER2_BIT]) begin
         vector_d = VEC_TIMER2;
      end
   end

   // The vector is registered so the core sees a clean value one cycle late.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         core_irq_vector <= VEC_RESET;
         core_irq_valid  <= 1'b0;
      end else begin
         core_irq_vector <= vector_d;
         core_irq_valid  <= |gated_req;
      end
   end

   // Write address and data are taken in either order and held until both are in.
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
   assign aw_hit        = s_axi_awvalid && s_axi_awready;
   assign w_hit         = s_axi_wvalid && s_axi_wready;
   assign do_write      = (aw_held_q || aw_hit) && (w_held_q || w_hit);
   assign wr_addr       = aw_held_q ? awaddr_q : s_axi_awaddr;
   assign wr_data       = w_held_q ? wdata_q : s_axi_wdata;
   assign wr_strb       = w_held_q ? wstrb_q : s_axi_wstrb;
   assign wr_byte0      = do_write && wr_strb[0];

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end else if (aw_hit) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         w_held_q <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= 4'h0;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end else if (w_hit) begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end
   end

   // Write address decode.
   always_comb begin
      wr_en_sel  = 1'b0;
      wr_cfg_sel = 1'b0;
      wr_sts_sel = 1'b0;
      wr_msk_sel = 1'b0;
      wr_mapped  = 1'b1;
      if (wr_addr == ADDR_IRQ_ENABLE) begin
         wr_en_sel = 1'b1;
      end else if (wr_addr == ADDR_MCU_CONFIG) begin
         wr_cfg_sel = 1'b1;
      end else if (wr_addr == ADDR_EVT_STATUS) begin
         wr_sts_sel = 1'b1;
      end else if (wr_addr == ADDR_EVT_MASK) begin
         wr_msk_sel = 1'b1;
      end else if (wr_addr == ADDR_REQ_STATUS || wr_addr == ADDR_VECTOR) begin
         wr_mapped = 1'b1;
      end else begin
         wr_mapped = 1'b0;
      end
   end

   // Read-only registers accept writes with OKAY and ignore the data.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= AXI_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Enable register; the reserved bit can never be set.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_enable_reg_q <= EN_RESET;
      end else if (wr_byte0 && wr_en_sel) begin
         irq_enable_reg_q <= wr_data[7:0] & EN_WRITE_MASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mcu_config_reg_q <= CFG_RESET;
      end else if (wr_byte0 && wr_cfg_sel) begin
         mcu_config_reg_q <= {7'h00, wr_data[CFG_IRQ1_SEL_BIT]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         evt_mask_q <= SRC_RESET;
      end else if (wr_byte0 && wr_msk_sel) begin
         evt_mask_q <= wr_data[NUM_SRC-1:0];
      end
   end

   // Sticky event bits are set by a rising raw request; a new event beats a clear.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         raw_req_q <= SRC_RESET;
      end else begin
         raw_req_q <= raw_req;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         evt_status_q <= SRC_RESET;
      end else begin
         evt_status_q <= (evt_status_q
                          & ~((wr_byte0 && wr_sts_sel) ? wr_data[NUM_SRC-1:0] : SRC_RESET))
                         | (raw_req & ~raw_req_q);
      end
   end

   assign irq = |(evt_status_q & evt_mask_q);

   // Read channel; one read is in flight at a time.
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_hit        = s_axi_arvalid && s_axi_arready;

   always_comb begin
      rd_data = '0;
      rd_resp = AXI_RESP_OKAY;
      if (s_axi_araddr == ADDR_IRQ_ENABLE) begin
         rd_data[7:0] = irq_enable_reg_q;
      end else if (s_axi_araddr == ADDR_MCU_CONFIG) begin
         rd_data[7:0] = mcu_config_reg_q;
      end else if (s_axi_araddr == ADDR_EVT_STATUS) begin
         rd_data[NUM_SRC-1:0] = evt_status_q;
      end else if (s_axi_araddr == ADDR_EVT_MASK) begin
         rd_data[NUM_SRC-1:0] = evt_mask_q;
      end else if (s_axi_araddr == ADDR_REQ_STATUS) begin
         rd_data[NUM_SRC-1:0] = raw_req;
      end else if (s_axi_araddr == ADDR_VECTOR) begin
         rd_data[15:0] = core_irq_vector;
      end else begin
         rd_resp = AXI_RESP_SLVERR;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= AXI_RESP_OKAY;
      end else if (ar_hit) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data;
         s_axi_rresp  <= rd_resp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : mcuie_ctrl

// ### mcuie_chk_sva.sv
`timescale 1ns/1ps
module mcuie_chk_sva
   import mcuie_pkg::*;
(
   // Clock and reset.
   input wire logic                  sys_clk,
   input wire logic                  rst_n,
   // Bus answers.
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic [1:0]            s_axi_bresp,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
   // Sources and core side.
   input wire logic [NUM_PERIPH-1:0] periph_irq,
   input wire logic                  timer0_irq,
   input wire logic                  serial_irq,
   input wire logic [PORT2_W-1:0]    port2_in_n,
   input wire logic                  internal_irq_line_n,
   input wire logic [NUM_SRC-1:0]    core_irq_req,
   input wire logic [15:0]           core_irq_vector,
   input wire logic                  core_irq_valid,
   input wire logic                  port2_irq_line_n
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   int_line_a: assert property (internal_irq_line_n == !(|periph_irq))
      else $error("internal line does not follow peripherals");
   int_gate_a: assert property (core_irq_req[0] |-> |periph_irq)
      else $error("internal request without a peripheral");
   t0_gate_a: assert property (core_irq_req[1] |-> timer0_irq)
      else $error("timer0 request without source");
   ser_gate_a: assert property (core_irq_req[4] |-> serial_irq)
      else $error("serial request without source");
   req_valid_a: assert property (|core_irq_req |=> core_irq_valid)
      else $error("valid missing after request");
   idle_vec_a: assert property (!(|core_irq_req) |=> !core_irq_valid &&
      core_irq_vector == VEC_RESET) else $error("idle vector wrong");
   vec_int_a: assert property (core_irq_req[0] |=> core_irq_vector == VEC_INTERNAL)
      else $error("internal vector wrong");
   vec_ext1_a: assert property (core_irq_req[2:0] == 3'h4 |=> core_irq_vector == VEC_EXT1)
      else $error("ext1 vector wrong");
   vec_ser_a: assert property (core_irq_req[4:0] == 5'h10 |=> core_irq_vector == VEC_SERIAL)
      else $error("serial vector wrong");
   p2_low_a: assert property (port2_in_n != 8'hff [*3] |-> !port2_irq_line_n)
      else $error("port2 line not low");
   p2_idle_a: assert property (port2_in_n == 8'hff [*3] |-> port2_irq_line_n)
      else $error("port2 line not idle");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule : mcuie_chk_sva

// ### mcuie_far.sv
`timescale 1ns/1ps
module mcuie_far
   import mcuie_pkg::*;
(
   // Clock and reset.
   input wire logic                  sys_clk,
   input wire logic                  rst_n,
   // Requests wanted by the bench, in core request bit order.
   input wire logic [NUM_SRC-1:0]    src,
   input wire logic                  p33_low,
   // Toward the block.
   output logic [NUM_PERIPH-1:0]     periph_irq,
   output logic                      timer0_irq,
   output logic                      timer1_irq,
   output logic                      timer2_irq,
   output logic                      serial_irq,
   output logic [PORT2_W-1:0]        port2_in_n,
   output logic                      p3_3_in_n,
   // Core side.
   input wire logic                  internal_irq_line_n,
   input wire logic                  core_irq_valid,
   input wire logic [15:0]           core_irq_vector,
   output logic [15:0]               taken_vec_q
);
   // Two peripherals ask at once so that the combining is really exercised.
   assign periph_irq = {src[0], 14'h0, src[0]};
   assign timer0_irq = src[1];
   assign timer1_irq = src[3];
   assign serial_irq = src[4];
   assign timer2_irq = src[5];
   // Pins have pull-ups, so an idle pin reads high.
   assign port2_in_n = src[2] ? 8'hdf : 8'hff;
   assign p3_3_in_n  = !p33_low;

   // The core treats the internal line as a low level, so it fetches while it stays asserted.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         taken_vec_q <= VEC_RESET;
      end else if (core_irq_valid
                   && (!internal_irq_line_n || core_irq_vector != VEC_INTERNAL)) begin
         taken_vec_q <= core_irq_vector;
      end
   end
endmodule : mcuie_far

// ### testbench.sv
`timescale 1ns/1ps
module testbench
   import mcuie_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [5:0]  src = 6'h00;
   logic        p33_low = 1'b0;
   logic [15:0] periph_irq;
   logic        timer0_irq, timer1_irq, timer2_irq, serial_irq, p3_3_in_n;
   logic [7:0]  port2_in_n;
   logic        internal_irq_line_n, core_irq_valid, port2_irq_line_n, irq;
   logic [5:0]  core_irq_req;
   logic [15:0] core_irq_vector, taken_vec_q;
   logic [15:0] vt [6];
   int          n_fail = 0;
   int          check_count = 0;

   always #20 sys_clk = ~sys_clk;

   mcuie_ctrl u_mcuie_ctrl (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .periph_irq, .timer0_irq, .timer1_irq, .timer2_irq,
      .serial_irq, .port2_in_n, .p3_3_in_n, .internal_irq_line_n, .core_irq_req,
      .core_irq_vector, .core_irq_valid, .port2_irq_line_n, .irq);
   mcuie_far u_mcuie_far (.sys_clk, .rst_n, .src, .p33_low, .periph_irq, .timer0_irq,
      .timer1_irq, .timer2_irq, .serial_irq, .port2_in_n, .p3_3_in_n, .internal_irq_line_n,
      .core_irq_valid, .core_irq_vector, .taken_vec_q);

   task automatic report_and_stop();
      if (n_fail == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task automatic guard(inout int n);
      n++;
      if (n > 40) begin
         n_fail++;
         report_and_stop();
      end
   endtask : guard

   // Ready is looked at mid-cycle, so the handshake edge never races the slave's own update.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ta, tw, ad, dd;
      logic [1:0] r;
      n = 0;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge sys_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         ad = ad | ta;
         dd = dd | tw;
         guard(n);
      end while (!(ad && dd));
      do begin
         @(negedge sys_clk);
         ta = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge sys_clk);
         guard(n);
      end while (!ta);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic t;
      logic [31:0] d;
      logic [1:0] r;
      n = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge sys_clk);
         t = s_axi_arvalid && s_axi_arready;
         @(posedge sys_clk);
         if (t) s_axi_arvalid <= 1'b0;
         guard(n);
      end while (!t);
      do begin
         @(negedge sys_clk);
         t = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge sys_clk);
         guard(n);
      end while (!t);
      s_axi_rready <= 1'b0;
      chk("rdata", ed, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask : rd

   // Pins pass two synchronising flops, so five cycles cover request, vector and core fetch.
   task automatic put(input logic [5:0] s, input logic p);
      @(posedge sys_clk);
      src <= s;
      p33_low <= p;
      repeat (5) @(negedge sys_clk);
   endtask : put

   task automatic t_reset();
      rd(ADDR_IRQ_ENABLE, 32'h0, AXI_RESP_OKAY);
      rd(ADDR_MCU_CONFIG, 32'h0, AXI_RESP_OKAY);
      wr(ADDR_IRQ_ENABLE, 32'hffffffff, AXI_RESP_OKAY);
      rd(ADDR_IRQ_ENABLE, 32'hbf, AXI_RESP_OKAY);
   endtask : t_reset

   task automatic t_gate();
      logic [5:0] m;
      wr(ADDR_MCU_CONFIG, 32'h1, AXI_RESP_OKAY);
      for (int i = 0; i < NUM_SRC; i++) begin
         m = 6'h01 << i;
         wr(ADDR_IRQ_ENABLE, {24'h0, 2'b10, m}, AXI_RESP_OKAY);
         put(m, 1'b0);
         chk("req", {26'h0, m}, {26'h0, core_irq_req});
         chk("vec", {16'h0, vt[i]}, {16'h0, core_irq_vector});
         chk("taken", {16'h0, vt[i]}, {16'h0, taken_vec_q});
         wr(ADDR_IRQ_ENABLE, {26'h0, m}, AXI_RESP_OKAY);
         @(negedge sys_clk);
         chk("noglobal", 32'h0, {26'h0, core_irq_req});
         wr(ADDR_IRQ_ENABLE, {24'h0, 2'b10, ~m}, AXI_RESP_OKAY);
         @(negedge sys_clk);
         chk("noown", 32'h0, {26'h0, core_irq_req});
         put(6'h00, 1'b0);
      end
   endtask : t_gate

   task automatic t_sel();
      wr(ADDR_MCU_CONFIG, 32'h0, AXI_RESP_OKAY);
      wr(ADDR_IRQ_ENABLE, 32'h84, AXI_RESP_OKAY);
      put(6'h00, 1'b1);
      chk("p33", 32'h4, {26'h0, core_irq_req});
      chk("p2idle", 32'h1, {31'h0, port2_irq_line_n});
      put(6'h04, 1'b0);
      chk("sel0", 32'h0, {26'h0, core_irq_req});
      chk("p2low", 32'h0, {31'h0, port2_irq_line_n});
      wr(ADDR_MCU_CONFIG, 32'h1, AXI_RESP_OKAY);
      @(negedge sys_clk);
      chk("sel1", 32'h4, {26'h0, core_irq_req});
      put(6'h00, 1'b0);
   endtask : t_sel

   task automatic t_prio();
      wr(ADDR_IRQ_ENABLE, 32'haa, AXI_RESP_OKAY);
      put(6'h28, 1'b0);
      chk("vt1", {16'h0, VEC_TIMER1}, {16'h0, core_irq_vector});
      put(6'h2a, 1'b0);
      chk("vt0", {16'h0, VEC_TIMER0}, {16'h0, core_irq_vector});
      rd(ADDR_VECTOR, {16'h0, VEC_TIMER0}, AXI_RESP_OKAY);
      put(6'h00, 1'b0);
      chk("vnone", {16'h0, VEC_RESET}, {16'h0, core_irq_vector});
   endtask : t_prio

   task automatic t_evt();
      wr(ADDR_EVT_STATUS, 32'h3f, AXI_RESP_OKAY);
      wr(ADDR_EVT_MASK, 32'h2, AXI_RESP_OKAY);
      @(negedge sys_clk);
      chk("irqoff", 32'h0, {31'h0, irq});
      put(6'h02, 1'b0);
      chk("irqon", 32'h1, {31'h0, irq});
      rd(ADDR_REQ_STATUS, 32'h2, AXI_RESP_OKAY);
      put(6'h00, 1'b0);
      wr(ADDR_EVT_STATUS, 32'h2, AXI_RESP_OKAY);
      @(negedge sys_clk);
      chk("irqclr", 32'h0, {31'h0, irq});
      wr(ADDR_EVT_MASK, 32'h0, AXI_RESP_OKAY);
      put(6'h02, 1'b0);
      chk("irqmask", 32'h0, {31'h0, irq});
      rd(ADDR_EVT_STATUS, 32'h2, AXI_RESP_OKAY);
      put(6'h00, 1'b0);
   endtask : t_evt

   task automatic t_bad();
      wr(8'h40, 32'h1, AXI_RESP_SLVERR);
      rd(8'h40, 32'h0, AXI_RESP_SLVERR);
      wr(ADDR_VECTOR, 32'hff, AXI_RESP_OKAY);
      s_axi_wstrb <= 4'h0;
      wr(ADDR_IRQ_ENABLE, 32'h0, AXI_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(ADDR_IRQ_ENABLE, 32'haa, AXI_RESP_OKAY);
   endtask : t_bad

   // A second reset in mid-run must bring the enable and configuration registers back to their cleared values.
   task automatic t_rerun();
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(ADDR_IRQ_ENABLE, 32'h0, AXI_RESP_OKAY);
      rd(ADDR_MCU_CONFIG, 32'h0, AXI_RESP_OKAY);
   endtask : t_rerun

   initial begin
      vt = '{VEC_INTERNAL, VEC_TIMER0, VEC_EXT1, VEC_TIMER1, VEC_SERIAL, VEC_TIMER2};
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_gate();
      t_sel();
      t_prio();
      t_evt();
      t_bad();
      t_rerun();
      report_and_stop();
   end
endmodule : testbench

bind mcuie_ctrl mcuie_chk_sva u_chk (.sys_clk, .rst_n, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .periph_irq, .timer0_irq,
   .serial_irq, .port2_in_n, .internal_irq_line_n, .core_irq_req, .core_irq_vector,
   .core_irq_valid, .port2_irq_line_n);
